// File: hdl/spm_defs.svh
// Register map, field positions and reset values of the serial peripheral master.
// Assumes inclusion by bare name from the design files only.
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

`define SPM_ADDR_CTRL 8'ha1
`define SPM_ADDR_DATA 8'ha2
`define SPM_ADDR_STAT 8'ha3
`define SPM_ADDR_IRQ_STAT 8'ha4
`define SPM_ADDR_IRQ_MASK 8'ha5

`define SPM_CTRL_EN 5
`define SPM_CTRL_ORDER 4
`define SPM_CTRL_CLOCK_POLARITY 3
`define SPM_CTRL_CLOCK_PHASE 2
`define SPM_CTRL_RATE_HI 1
`define SPM_CTRL_RATE_LO 0
`define SPM_CTRL_STORED 6
`define SPM_CTRL_RESET 7'h00

`define SPM_STAT_WRITE_COLLISION 0
`define SPM_STAT_ACTIVE 1

`define SPM_IRQ_DONE 0
`define SPM_IRQ_COLL 1
`define SPM_IRQ_RESET 2'h0

`define SPM_DATA_RESET 8'h00
`define SPM_HALF_BASE 6'h04
`define SPM_EDGE_LAST 4'hf

`endif

// File: hdl/spm_pkg.sv
// Types shared by the serial peripheral master.
// Assumes the defines header is compiled alongside.
package spm_pkg;

	typedef enum logic [1:0]
	{
		SPM_IDLE = 2'b01,
		SPM_SHIFT = 2'b10
	} spm_state_type;

endpackage : spm_pkg

// File: hdl/spm_top.sv
// Byte-wide serial peripheral master with control, data and status registers.
// Assumes a single-cycle strobe register port and a slave select driven elsewhere.
`timescale 1ns/1ps
`include "spm_defs.svh"

module spm_top
	import spm_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic port_direction,
	output logic sck,
	output logic sck_oe,
	output logic master_data_out,
	output logic master_data_out_oe,
	input wire logic master_data_in,
	output logic irq
);

	function automatic logic first_bit(input logic [7:0] d, input logic msb);
		first_bit = msb ? d[7] : d[0];
	endfunction : first_bit

	function automatic logic [7:0] shift_out(input logic [7:0] d, input logic msb);
		shift_out = msb ? {d[6:0], 1'b0} : {1'b0, d[7:1]};
	endfunction : shift_out

	function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic msb);
		shift_in = msb ? {d[6:0], b} : {b, d[7:1]};
	endfunction : shift_in

	spm_state_type state_q;
	logic [6:0] ctrl_q;
	logic [4:0] div_cnt_q;
	logic [3:0] edge_cnt_q;
	logic sck_q;
	logic mo_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] rxbuf_q;
	logic write_collision_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [7:0] rdata_q;

	logic en;
	logic msb_first;
	logic clock_polarity;
	logic clock_phase;
	logic [1:0] rate;
	logic [4:0] half_m1;
	logic busy;
	logic wr_ctrl;
	logic wr_data;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic start;
	logic tick;
	logic done;
	logic leading;
	logic sample;
	logic launch;
	logic [7:0] rx_in;
	logic [1:0] irq_evt;

	assign en = ctrl_q[`SPM_CTRL_EN];
	assign msb_first = ctrl_q[`SPM_CTRL_ORDER];
	assign clock_polarity = ctrl_q[`SPM_CTRL_CLOCK_POLARITY];
	assign clock_phase = ctrl_q[`SPM_CTRL_CLOCK_PHASE];
	assign rate = ctrl_q[`SPM_CTRL_RATE_HI:`SPM_CTRL_RATE_LO];
	// Half period is 4, 8, 16 or 32 clocks for the four codes
	assign half_m1 = 5'((`SPM_HALF_BASE << rate) - 6'h01);
	assign busy = (state_q == SPM_SHIFT);

	assign wr_ctrl = reg_wr && (reg_addr == `SPM_ADDR_CTRL);
	assign wr_data = reg_wr && (reg_addr == `SPM_ADDR_DATA);
	assign wr_irq_stat = reg_wr && (reg_addr == `SPM_ADDR_IRQ_STAT);
	assign wr_irq_mask = reg_wr && (reg_addr == `SPM_ADDR_IRQ_MASK);

	assign start = wr_data && en && !busy;
	assign tick = busy && (div_cnt_q == half_m1);
	assign done = tick && (edge_cnt_q == `SPM_EDGE_LAST);
	assign leading = ~edge_cnt_q[0];
	assign sample = tick && (leading ^ clock_phase);
	assign launch = tick && (leading == clock_phase);
	assign rx_in = shift_in(rx_q, master_data_in, msb_first);

	always_ff @(posedge mclk)
	begin
		if (reset)
			ctrl_q <= `SPM_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= reg_wdata[`SPM_CTRL_STORED:0];
	end

	// Disabling mid-byte aborts the transfer; the buffer keeps its old byte
	always_ff @(posedge mclk)
	begin
		if (reset)
			state_q <= SPM_IDLE;
		else if (!en)
			state_q <= SPM_IDLE;
		else if (start)
			state_q <= SPM_SHIFT;
		else if (done)
			state_q <= SPM_IDLE;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			div_cnt_q <= '0;
		else if (!busy || tick)
			div_cnt_q <= '0;
		else
			div_cnt_q <= div_cnt_q + 5'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			edge_cnt_q <= '0;
		else if (!busy)
			edge_cnt_q <= '0;
		else if (tick)
			edge_cnt_q <= edge_cnt_q + 4'h1;
	end

	// Sixteen toggles per byte, so the clock ends at its idle level
	always_ff @(posedge mclk)
	begin
		if (reset)
			sck_q <= 1'b0;
		else if (!busy)
			sck_q <= clock_polarity;
		else if (tick)
			sck_q <= ~sck_q;
	end

	// Phase 0 puts the first bit out before the first clock edge
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			tx_q <= `SPM_DATA_RESET;
			mo_q <= 1'b0;
		end
		else if (start)
		begin
			tx_q <= clock_phase ? reg_wdata : shift_out(reg_wdata, msb_first);
			mo_q <= clock_phase ? mo_q : first_bit(reg_wdata, msb_first);
		end
		else if (launch)
		begin
			tx_q <= shift_out(tx_q, msb_first);
			mo_q <= first_bit(tx_q, msb_first);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			rx_q <= `SPM_DATA_RESET;
		else if (sample)
			rx_q <= rx_in;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			rxbuf_q <= `SPM_DATA_RESET;
		else if (done)
			rxbuf_q <= sample ? rx_in : rx_q;
	end

	// Collision write is dropped: nothing else takes the data
	always_ff @(posedge mclk)
	begin
		if (reset)
			write_collision_q <= 1'b0;
		else if (wr_data)
			write_collision_q <= busy;
	end

	assign irq_evt[`SPM_IRQ_DONE] = done;
	assign irq_evt[`SPM_IRQ_COLL] = wr_data && busy;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (reset)
			irq_stat_q <= `SPM_IRQ_RESET;
		else if (wr_irq_stat)
			irq_stat_q <= (irq_stat_q & ~reg_wdata[1:0]) | irq_evt;
		else
			irq_stat_q <= irq_stat_q | irq_evt;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			irq_mask_q <= `SPM_IRQ_RESET;
		else if (wr_irq_mask)
			irq_mask_q <= reg_wdata[1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			rdata_q <= `SPM_DATA_RESET;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`SPM_ADDR_CTRL: rdata_q <= {1'b0, ctrl_q};
				`SPM_ADDR_DATA: rdata_q <= rxbuf_q;
				`SPM_ADDR_STAT: rdata_q <= {6'h00, busy, write_collision_q};
				`SPM_ADDR_IRQ_STAT: rdata_q <= {6'h00, irq_stat_q};
				`SPM_ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
				default: rdata_q <= `SPM_DATA_RESET;
			endcase
		end
		else
			rdata_q <= `SPM_DATA_RESET;
	end

	assign reg_rdata = rdata_q;
	assign sck = sck_q;
	assign sck_oe = en;
	assign master_data_out = mo_q;
	// Direction bit set turns the output pin around for a shared data line
	assign master_data_out_oe = en && !port_direction;
	assign irq = |(irq_stat_q & irq_mask_q);

	a_disabled_idle: assert property (@(posedge mclk) disable iff (reset)
		!en |=> !busy)
		else $error("transfer active while disabled");

	a_idle_clock_level: assert property (@(posedge mclk) disable iff (reset)
		(!busy && !$past(busy) && $stable(clock_polarity)) |-> (sck_q == clock_polarity))
		else $error("clock not at idle level");

	a_start_sets_active: assert property (@(posedge mclk) disable iff (reset)
		start |=> busy && (edge_cnt_q == 4'h0))
		else $error("enabled data write did not start");

	a_first_msb_bit: assert property (@(posedge mclk) disable iff (reset)
		(start && !clock_phase && msb_first) |=> (mo_q == $past(reg_wdata[7])))
		else $error("first bit wrong for msb order");

	a_first_lsb_bit: assert property (@(posedge mclk) disable iff (reset)
		(start && !clock_phase && !msb_first) |=> (mo_q == $past(reg_wdata[0])))
		else $error("first bit wrong for lsb order");

	a_rate_slowest: assert property (@(posedge mclk) disable iff (reset)
		(start && rate == 2'h3) ##1 (busy && rate == 2'h3) [*8]
		|-> $stable(sck_q))
		else $error("clock toggled early at slowest rate");

	a_collision_kept: assert property (@(posedge mclk) disable iff (reset)
		(wr_data && busy && !done) |=> busy && write_collision_q)
		else $error("collision disturbed transfer");

	a_collision_flag: assert property (@(posedge mclk) disable iff (reset)
		wr_data |=> (write_collision_q == $past(busy)))
		else $error("collision flag not updated");

	a_buffer_on_done: assert property (@(posedge mclk) disable iff (reset)
		(rxbuf_q != $past(rxbuf_q)) |-> $past(done))
		else $error("receive buffer changed mid transfer");

	a_done_clears: assert property (@(posedge mclk) disable iff (reset)
		done |=> !busy && (sck_q == clock_polarity))
		else $error("active not cleared at completion");

	a_status_active: assert property (@(posedge mclk) disable iff (reset)
		(reg_rd && reg_addr == `SPM_ADDR_STAT) |=>
		(reg_rdata[`SPM_STAT_ACTIVE] == $past(busy)) && (reg_rdata[7:2] == 6'h00))
		else $error("status read wrong");

	a_pins_owned: assert property (@(posedge mclk) disable iff (reset)
		$rose(en) |-> sck_oe && (master_data_out_oe == !port_direction))
		else $error("pins not taken over");

	c_transfer_done: cover property (@(posedge mclk) disable iff (reset) done);
	c_collision: cover property (@(posedge mclk) disable iff (reset) wr_data && busy);
	c_back_to_back: cover property (@(posedge mclk) disable iff (reset) done ##1 start);
	c_irq_raised: cover property (@(posedge mclk) disable iff (reset) $rose(irq));

endmodule : spm_top

// File: sim/spm_slave_model.sv
// Behavioural serial slave facing the master's clock and data pins.
// Assumes the bench sets order, polarity and phase and arms it before each byte.
`timescale 1ns/1ps
module spm_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic clock_polarity,
	input wire logic clock_phase,
	input wire logic msb_first,
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh = 8'h00;
	logic first = 1'b0;
	initial miso = 1'b0;
	initial rx = 8'h00;
	task automatic arm(input logic [7:0] t);
		sh = t;
		first = 1'b1;
		miso = msb_first ? t[7] : t[0];
	endtask : arm
	// Sample and launch never share an edge, so no race with the master's data
	always @(sck)
	begin
		if ((sck !== clock_polarity) == !clock_phase)
			rx = msb_first ? {rx[6:0], mosi} : {mosi, rx[7:1]};
		else if (first && clock_phase)
			first = 1'b0;
		else
		begin
			sh = msb_first ? sh << 1 : sh >> 1;
			miso = msb_first ? sh[7] : sh[0];
		end
	end
endmodule : spm_slave_model

// File: sim/serial_peripheral_master_bench.sv
// Bench of the serial master: register tasks, a sweep of all modes, abort and interrupts.
// Assumes the slave model is compiled first; no slave select is modelled.
`timescale 1ns/1ps
module serial_peripheral_master_bench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic port_direction = 1'b0;
	logic [7:0] reg_rdata, slv_rx, prev = 8'h00;
	logic sck, sck_oe, mo, mo_oe, mi, irq;
	logic clock_polarity = 1'b0;
	logic clock_phase = 1'b0;
	logic msb = 1'b0;
	logic sck_prev = 1'b0;
	logic [7:0] regs [6] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'h10};
	int mismatches = 0;
	int num_checks = 0;
	int toggles = 0;
	int gap = 0;
	int cnt = 0;

	spm_top i_dut (
		.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_direction(port_direction), .sck(sck), .sck_oe(sck_oe),
		.master_data_out(mo), .master_data_out_oe(mo_oe), .master_data_in(mi), .irq(irq)
	);
	spm_slave_model i_slave (
		.sck(sck), .mosi(mo), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .msb_first(msb),
		.miso(mi), .rx(slv_rx)
	);

	initial
	begin
		forever #2.5 mclk = ~mclk;
	end

	// Edge counter; gap holds mclk cycles between the last two clock toggles
	always @(posedge mclk)
	begin
		if (sck !== sck_prev)
		begin
			toggles++;
			gap = cnt;
			cnt = 1;
		end
		else
			cnt++;
		sck_prev = sck;
	end

	task automatic print_verdict();
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(nm, exp, reg_rdata);
		@(posedge mclk);
	endtask : rd

	initial
	begin
		logic [7:0] d;
		logic [7:0] s;
		int h;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		foreach (regs[k]) rd(regs[k], 8'h00, "reset value");
		wr(8'ha1, 8'hbf);
		rd(8'ha1, 8'h3f, "ctrl");
		chk("sck idle", 8'h01, {7'h00, sck});
		chk("sck_oe", 8'h01, {7'h00, sck_oe});
		port_direction <= 1'b1;
		@(posedge mclk);
		chk("mo_oe", 8'h00, {7'h00, mo_oe});
		port_direction <= 1'b0;
		wr(8'ha1, 8'h00);
		chk("sck_oe off", 8'h00, {7'h00, sck_oe});
		wr(8'ha2, 8'h55);
		rd(8'ha3, 8'h00, "status off");
		for (int i = 0; i < 8; i++)
		begin
			msb = i[2];
			clock_polarity = i[1];
			clock_phase = i[0];
			h = 4 << i[1:0];
			d = 8'h3a ^ 8'(i * 17);
			s = 8'hc1 + 8'(i);
			wr(8'ha1, {3'b001, msb, clock_polarity, clock_phase, 2'(i)});
			// Idle-level change is counted one edge late, so let it pass first
			repeat (2) @(posedge mclk);
			toggles = 0;
			i_slave.arm(s);
			wr(8'ha2, d);
			rd(8'ha3, 8'h02, "status busy");
			rd(8'ha2, prev, "rx hold");
			wr(8'ha2, ~d);
			rd(8'ha3, 8'h03, "status coll");
			repeat (16 * h) @(posedge mclk);
			rd(8'ha3, 8'h01, "status done");
			rd(8'ha2, s, "rx byte");
			chk("slave rx", d, slv_rx);
			chk("toggles", 8'h10, 8'(toggles));
			chk("half period", 8'(h), 8'(gap));
			chk("sck rest", {7'h00, clock_polarity}, {7'h00, sck});
			prev = s;
		end
		// Abort mid-byte must leave the receive buffer alone
		wr(8'ha1, 8'h20);
		wr(8'ha2, 8'h81);
		repeat (10) @(posedge mclk);
		wr(8'ha1, 8'h00);
		rd(8'ha3, 8'h00, "status abort");
		chk("sck abort", 8'h00, {7'h00, sck});
		rd(8'ha2, prev, "rx abort");
		chk("irq masked", 8'h00, {7'h00, irq});
		rd(8'ha4, 8'h03, "irq status");
		wr(8'ha5, 8'h01);
		chk("irq on", 8'h01, {7'h00, irq});
		wr(8'ha4, 8'h01);
		chk("irq clear", 8'h00, {7'h00, irq});
		rd(8'ha4, 8'h02, "irq left");
		wr(8'ha5, 8'h02);
		chk("irq coll", 8'h01, {7'h00, irq});
		print_verdict();
	end

	// Longest sweep needs about 2100 cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		print_verdict();
	end
endmodule : serial_peripheral_master_bench
